// ---- common/sbpf_pkg.sv ----
`default_nettype none
package sbpf_pkg;
   // APB register map, byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_POS_UP   = 8'h04;
   localparam logic [7:0] ADDR_POS_LO   = 8'h08;
   localparam logic [7:0] ADDR_BR1_DIAG = 8'h0C;
   localparam logic [7:0] ADDR_BR2_DIAG = 8'h10;
   localparam logic [7:0] ADDR_HS_DIAG  = 8'h14;
   localparam logic [7:0] ADDR_STATUS   = 8'h18;

   // bridge_control_reg fields
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_DIR_BIT    = 1;
   localparam int CTRL_STEP_BIT   = 2;
   localparam int CTRL_SINGLE_BIT = 3;
   localparam int CTRL_SRST_BIT   = 4;
   localparam int CTRL_HS_LSB     = 8;

   // position counter layout and reset value
   localparam int            POS_W     = 10;
   localparam int            HALF_W    = 5;
   localparam int            TAG_LSB   = 5;
   localparam logic [9:0]    POS_RESET = 10'h200;
   localparam logic [9:0]    POS_MAX   = 10'h3FF;
   localparam logic [9:0]    POS_MIN   = 10'h000;
   localparam logic [1:0]    PHASE_RESET = 2'h0;

   // timing
   localparam int CLK_PERIOD_NS    = 40;
   localparam int BR_BLANK_MS      = 1;
   localparam int BR_OFF_DGC_US    = 125;
   localparam int BR_OVC_DGC_US    = 10;
   localparam int BR_LOWCUR_DGC_US = 20;
   localparam int HS_OVC_FILT_US   = 4;
   localparam int HS_OFF_FILT_US   = 7;
   localparam int HS_BLANK_US      = 1200;

   localparam int BR_BLANK_CYC_D   = (BR_BLANK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HS_BLANK_CYC_D   = (HS_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W            = 16;
   localparam logic [15:0] BR_OFF_DGC_CYC =
      16'((BR_OFF_DGC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] BR_OVC_DGC_CYC =
      16'((BR_OVC_DGC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] BR_LOWCUR_DGC_CYC =
      16'((BR_LOWCUR_DGC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] HS_OVC_FILT_CYC =
      16'((HS_OVC_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] HS_OFF_FILT_CYC =
      16'((HS_OFF_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      BR_OK, BR_GND_OFF, BR_BATT_OFF, BR_OPEN_OFF, BR_OVC, BR_RUNNING, BR_OPEN_ON, BR_GND_ON
   } sbpf_br_code_t;

   typedef enum logic [1:0] {HS_OK, HS_OVC, HS_BATT, HS_OPEN} sbpf_hs_code_t;

   typedef struct packed {
      logic ovc;
      logic low_cur;
      logic above_upper;
      logic above_lower;
   } sbpf_br_sense_t;

   typedef struct packed {
      logic ovc;
      logic above_upper;
      logic above_lower;
   } sbpf_hs_sense_t;
endpackage
`default_nettype wire

// ---- verilog/sbpf_top.sv ----
`default_nettype none
module sbpf_top #(
   parameter logic [15:0] BR_BLANK_CYC = 16'(sbpf_pkg::BR_BLANK_CYC_D),
   parameter logic [15:0] HS_BLANK_CYC = 16'(sbpf_pkg::HS_BLANK_CYC_D)
) (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire sbpf_pkg::sbpf_br_sense_t [1:0] br_sense,
   input  wire sbpf_pkg::sbpf_hs_sense_t [3:0] hs_sense,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic [7:0]                         drive,
   output logic                               global_fault_flag
);
   import sbpf_pkg::*;

   logic            rst_q1, rst_q2;
   logic            rstn_s;
   sbpf_br_sense_t [1:0] br_s1, br_s2;
   sbpf_hs_sense_t [3:0] hs_s1, hs_s2;
   logic            pready_r, pslverr_r;
   logic [31:0]     prdata_r;
   logic [31:0]     rd_mux;
   logic            rd_hit;
   logic            acc, done, wr_ctrl, rd_start;
   logic            clr_br1, clr_br2, clr_hs;
   logic            ctrl_en_r, ctrl_dir_r, ctrl_step_r, ctrl_single_r;
   logic [3:0]      hs_cmd_r;
   logic            step_ev, en_rise, soft_rst;
   logic [1:0]      phase_r;
   logic [9:0]      pos_r;
   logic [1:0]      tag_r;
   logic [1:0]      br_on;
   logic [1:0]      br_shut;
   sbpf_br_code_t   br_code [2];
   logic [3:0]      hs_on;
   sbpf_hs_code_t   hs_code [4];
   logic [7:0]      drive_r;
   logic            gff_r;

   // reset release through two flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end
   assign rstn_s = rst_q2;

   // comparator pins are asynchronous to clock
   always_ff @(posedge clock or negedge rstn_s) begin
      if (!rstn_s) begin
         br_s1 <= '0;
         br_s2 <= '0;
         hs_s1 <= '0;
         hs_s2 <= '0;
      end else if (ce) begin
         br_s1 <= br_sense;
         br_s2 <= br_s1;
         hs_s1 <= hs_sense;
         hs_s2 <= hs_s1;
      end
   end

   // apb: one wait state, answer on second access cycle
   assign acc      = psel & penable;
   assign done     = acc & pready_r;
   assign rd_start = acc & ~pready_r & ~pwrite;
   assign wr_ctrl  = done & pwrite & (paddr == ADDR_CTRL);
   assign clr_br1  = rd_start & (paddr == ADDR_BR1_DIAG);
   assign clr_br2  = rd_start & (paddr == ADDR_BR2_DIAG);
   assign clr_hs   = rd_start & (paddr == ADDR_HS_DIAG);

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (paddr)
         ADDR_CTRL: begin
            rd_mux[CTRL_EN_BIT]     = ctrl_en_r;
            rd_mux[CTRL_DIR_BIT]    = ctrl_dir_r;
            rd_mux[CTRL_STEP_BIT]   = ctrl_step_r;
            rd_mux[CTRL_SINGLE_BIT] = ctrl_single_r;
            rd_mux[CTRL_HS_LSB +: 4] = hs_cmd_r;
         end
         ADDR_POS_UP: begin
            rd_mux[HALF_W-1:0]     = pos_r[POS_W-1:HALF_W];
            rd_mux[TAG_LSB +: 2]   = tag_r;
         end
         ADDR_POS_LO: begin
            rd_mux[HALF_W-1:0]     = pos_r[HALF_W-1:0];
            rd_mux[TAG_LSB +: 2]   = tag_r;
         end
         ADDR_BR1_DIAG: begin
            rd_mux[2:0] = br_code[0];
            rd_mux[3]   = br_shut[0];
         end
         ADDR_BR2_DIAG: begin
            rd_mux[2:0] = br_code[1];
            rd_mux[3]   = br_shut[1];
         end
         ADDR_HS_DIAG: begin
            rd_mux[7:0] = {hs_code[3], hs_code[2], hs_code[1], hs_code[0]};
         end
         ADDR_STATUS: begin
            rd_mux[0]   = gff_r;
            rd_mux[2:1] = br_shut;
            rd_mux[4:3] = phase_r;
            rd_mux[8:5] = hs_on;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn_s) begin
      if (!rstn_s) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else if (ce) begin
         pready_r <= acc & ~pready_r;
         if (acc & ~pready_r) begin
            // data captured on the same edge that clears read-clear registers
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_r <= ~rd_hit;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // command decode; en and step in one write counts as enable only
   assign step_ev  = wr_ctrl & pwdata[CTRL_STEP_BIT] & ~ctrl_step_r & ctrl_en_r
                   & pwdata[CTRL_EN_BIT] & ~ctrl_single_r;
   assign en_rise  = wr_ctrl & pwdata[CTRL_EN_BIT] & ~ctrl_en_r;
   assign soft_rst = wr_ctrl & pwdata[CTRL_SRST_BIT];

   always_ff @(posedge clock or negedge rstn_s) begin
      if (!rstn_s) begin
         ctrl_en_r     <= 1'b0;
         ctrl_dir_r    <= 1'b0;
         ctrl_step_r   <= 1'b0;
         ctrl_single_r <= 1'b0;
         hs_cmd_r      <= 4'h0;
      end else if (ce && wr_ctrl) begin
         ctrl_en_r     <= pwdata[CTRL_EN_BIT];
         ctrl_dir_r    <= pwdata[CTRL_DIR_BIT];
         ctrl_step_r   <= pwdata[CTRL_STEP_BIT];
         ctrl_single_r <= pwdata[CTRL_SINGLE_BIT];
         hs_cmd_r      <= pwdata[CTRL_HS_LSB +: 4];
      end
   end

   // sequence phase and position counter; step uses direction already held
   always_ff @(posedge clock or negedge rstn_s) begin
      if (!rstn_s) begin
         phase_r <= PHASE_RESET;
         pos_r   <= POS_RESET;
         tag_r   <= 2'h0;
      end else if (ce) begin
         if (step_ev) begin
            phase_r <= ctrl_dir_r ? phase_r + 2'h1 : phase_r - 2'h1;
         end
         if (soft_rst) begin
            pos_r <= POS_RESET;
            tag_r <= 2'h0;
         end else if (step_ev) begin
            tag_r <= tag_r + 2'h1;
            if (ctrl_dir_r && pos_r != POS_MAX) begin
               pos_r <= pos_r + 10'h001;
            end else if (!ctrl_dir_r && pos_r != POS_MIN) begin
               pos_r <= pos_r - 10'h001;
            end
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_br
         logic           on_q, shut_r, clr;
         logic [15:0]    blank_cnt, off_cnt, ovc_cnt, lc_cnt;
         logic [1:0]     kind, kind_q;
         logic           off_cond, ovc_cond, lc_cond;
         logic           off_ev, ovc_ev, lc_ev;
         sbpf_br_code_t  code_r;
         sbpf_br_sense_t s;

         assign s   = br_s2[gi];
         assign clr = (gi == 0) ? clr_br1 : clr_br2;
         // off fault does not gate turn-on
         assign br_on[gi] = ctrl_en_r & ~ctrl_single_r & ~shut_r;
         assign kind = s.above_upper ? 2'h2 : (!s.above_lower ? 2'h1 : 2'h0);
         assign off_cond = ~br_on[gi] & ~ctrl_single_r & (blank_cnt == 16'h0000)
                         & (kind != 2'h0) & (kind == kind_q);
         assign ovc_cond = br_on[gi] & s.ovc;
         assign lc_cond  = br_on[gi] & s.low_cur & ~clr;
         assign off_ev   = off_cond & (off_cnt == BR_OFF_DGC_CYC - 16'h0001);
         assign ovc_ev   = ovc_cond & (ovc_cnt == BR_OVC_DGC_CYC - 16'h0001);
         assign lc_ev    = lc_cond & (lc_cnt == BR_LOWCUR_DGC_CYC - 16'h0001);

         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               on_q      <= 1'b0;
               kind_q    <= 2'h0;
               blank_cnt <= 16'h0000;
            end else if (ce) begin
               on_q   <= br_on[gi];
               kind_q <= kind;
               if (on_q != br_on[gi]) begin
                  blank_cnt <= BR_BLANK_CYC;
               end else if (blank_cnt != 16'h0000) begin
                  blank_cnt <= blank_cnt - 16'h0001;
               end
            end
         end

         // deglitch counters, saturating at their limit
         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               off_cnt <= 16'h0000;
               ovc_cnt <= 16'h0000;
               lc_cnt  <= 16'h0000;
            end else if (ce) begin
               off_cnt <= !off_cond ? 16'h0000 :
                          (off_cnt != BR_OFF_DGC_CYC) ? off_cnt + 16'h0001 : off_cnt;
               ovc_cnt <= !ovc_cond ? 16'h0000 :
                          (ovc_cnt != BR_OVC_DGC_CYC) ? ovc_cnt + 16'h0001 : ovc_cnt;
               lc_cnt  <= !lc_cond ? 16'h0000 :
                          (lc_cnt != BR_LOWCUR_DGC_CYC) ? lc_cnt + 16'h0001 : lc_cnt;
            end
         end

         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               shut_r <= 1'b0;
            end else if (ce) begin
               if (ovc_ev) begin
                  shut_r <= 1'b1;
               end else if (step_ev || en_rise) begin
                  shut_r <= 1'b0;
               end
            end
         end

         // event branches sit above the read clear so an overcurrent or off set wins; the clear masks the low-current set
         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               code_r <= BR_OK;
            end else if (ce) begin
               if (ovc_ev) begin
                  code_r <= BR_OVC;
               end else if (off_ev && (code_r == BR_OK || clr)) begin
                  code_r <= (kind == 2'h2) ? BR_BATT_OFF :
                            (kind == 2'h1) ? BR_GND_OFF : BR_OPEN_OFF;
               end else if (lc_ev && (code_r == BR_OK || code_r == BR_GND_OFF ||
                                      code_r == BR_BATT_OFF || code_r == BR_OPEN_OFF)) begin
                  code_r <= BR_RUNNING;
               end else if (step_ev && code_r == BR_RUNNING) begin
                  code_r <= s.low_cur ? BR_OPEN_ON : BR_GND_ON;
               end else if (br_on[gi] && !s.low_cur &&
                            (code_r == BR_RUNNING || code_r == BR_OPEN_ON)) begin
                  code_r <= BR_OK;
               end else if (clr) begin
                  code_r <= BR_OK;
               end
            end
         end

         assign br_shut[gi] = shut_r;
         assign br_code[gi] = code_r;
      end

      for (gi = 0; gi < 4; gi++) begin : g_hs
         logic           on_q, shut_r, cmd;
         logic [15:0]    blank_cnt, off_cnt, ovc_cnt;
         logic [1:0]     kind, kind_q;
         logic           off_cond, ovc_cond, off_ev, ovc_ev;
         sbpf_hs_code_t  code_r;
         sbpf_hs_sense_t s;

         assign s   = hs_s2[gi];
         assign cmd = hs_cmd_r[gi] & ctrl_single_r;
         assign hs_on[gi] = cmd & ~shut_r;
         assign kind = s.above_upper ? 2'h2 : (s.above_lower ? 2'h1 : 2'h0);
         assign off_cond = ctrl_single_r & ~hs_on[gi] & (blank_cnt == 16'h0000)
                         & (kind != 2'h0) & (kind == kind_q);
         assign ovc_cond = hs_on[gi] & s.ovc;
         assign off_ev   = off_cond & (off_cnt == HS_OFF_FILT_CYC - 16'h0001);
         assign ovc_ev   = ovc_cond & (ovc_cnt == HS_OVC_FILT_CYC - 16'h0001);

         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               on_q      <= 1'b0;
               kind_q    <= 2'h0;
               blank_cnt <= 16'h0000;
               off_cnt   <= 16'h0000;
               ovc_cnt   <= 16'h0000;
            end else if (ce) begin
               on_q   <= hs_on[gi];
               kind_q <= kind;
               if (on_q && !hs_on[gi]) begin
                  blank_cnt <= HS_BLANK_CYC;
               end else if (blank_cnt != 16'h0000) begin
                  blank_cnt <= blank_cnt - 16'h0001;
               end
               off_cnt <= !off_cond ? 16'h0000 :
                          (off_cnt != HS_OFF_FILT_CYC) ? off_cnt + 16'h0001 : off_cnt;
               ovc_cnt <= !ovc_cond ? 16'h0000 :
                          (ovc_cnt != HS_OVC_FILT_CYC) ? ovc_cnt + 16'h0001 : ovc_cnt;
            end
         end

         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               shut_r <= 1'b0;
            end else if (ce) begin
               if (ovc_ev) begin
                  shut_r <= 1'b1;
               end else if (!cmd || clr_hs) begin
                  shut_r <= 1'b0;
               end
            end
         end

         always_ff @(posedge clock or negedge rstn_s) begin
            if (!rstn_s) begin
               code_r <= HS_OK;
            end else if (ce) begin
               if (ovc_ev) begin
                  code_r <= HS_OVC;
               end else if (off_ev && (code_r == HS_OK || clr_hs)) begin
                  code_r <= (kind == 2'h2) ? HS_BATT : HS_OPEN;
               end else if (clr_hs) begin
                  code_r <= HS_OK;
               end
            end
         end

         assign hs_code[gi] = code_r;
      end
   endgenerate

   // gate drive and global flag, registered so outputs come off flops
   always_ff @(posedge clock or negedge rstn_s) begin
      if (!rstn_s) begin
         drive_r <= 8'h00;
         gff_r   <= 1'b0;
      end else if (ce) begin
         drive_r <= 8'h00;
         if (ctrl_single_r) begin
            // low sides in single-stage mode stay off from the default clear
            drive_r[0] <= hs_on[0];
            drive_r[2] <= hs_on[1];
            drive_r[4] <= hs_on[2];
            drive_r[5] <= hs_on[3];
         end else begin
            if (br_on[0]) begin
               drive_r[0] <= ~phase_r[1];
               drive_r[3] <= ~phase_r[1];
               drive_r[2] <= phase_r[1];
               drive_r[1] <= phase_r[1];
            end
            if (br_on[1]) begin
               drive_r[4] <= phase_r[1] ^ phase_r[0];
               drive_r[7] <= phase_r[1] ^ phase_r[0];
               drive_r[5] <= ~(phase_r[1] ^ phase_r[0]);
               drive_r[6] <= ~(phase_r[1] ^ phase_r[0]);
            end
         end
         gff_r <= (br_code[0] != BR_OK) | (br_code[1] != BR_OK) | (hs_code[0] != HS_OK)
                | (hs_code[1] != HS_OK) | (hs_code[2] != HS_OK) | (hs_code[3] != HS_OK);
      end
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign drive             = drive_r;
   assign global_fault_flag = gff_r;
endmodule
`default_nettype wire

// ---- bench/sbpf_properties.sv ----
`default_nettype none
module sbpf_properties (
   input wire logic                       clock,
   input wire logic                       rst_n,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [7:0]                 paddr,
   input wire logic [31:0]                pwdata,
   input wire sbpf_pkg::sbpf_br_sense_t [1:0] br_sense,
   input wire sbpf_pkg::sbpf_hs_sense_t [3:0] hs_sense,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [7:0]                 drive,
   input wire logic                       global_fault_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   import sbpf_pkg::*;
   logic [15:0] br_cnt_r;
   logic [15:0] hs_cnt_r;
   logic        wr_ctrl;
   assign wr_ctrl = pready && pwrite && paddr == ADDR_CTRL;
   // consecutive cycles a stage stays on into an overcurrent
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) br_cnt_r <= 16'h0000;
      else br_cnt_r <= ((|drive[3:0]) && br_sense[0].ovc) ? br_cnt_r + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) hs_cnt_r <= 16'h0000;
      else hs_cnt_r <= (drive[0] && hs_sense[0].ovc) ? hs_cnt_r + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_apb_one_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
      else $error("no answer one cycle into access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
      else $error("error response wrong for address");
   a_hs_ovc_shut: assert property (hs_cnt_r <= 16'd110)
      else $error("high side not shut after overcurrent filter");
   a_br_ovc_shut: assert property (br_cnt_r <= 16'd262)
      else $error("bridge not shut after overcurrent deglitch");
   a_no_step_low: assert property (wr_ctrl && pwdata[0] && !pwdata[2] && !pwdata[3] && drive != 8'h00
      |=> ##1 drive == $past(drive, 2)) else $error("drive moved without step edge");
   a_flag_on_read: assert property (pready && !pwrite && paddr == ADDR_BR1_DIAG
      && prdata[2:0] != 3'h0 |-> global_fault_flag) else $error("fault without flag");
   a_lowside_cmd: assert property (!drive[1] && !drive[3] && !wr_ctrl && !$past(wr_ctrl)
      |=> !drive[1] && !drive[3]) else $error("low side on without command");
   c_br_ovc: cover property (br_cnt_r == 16'd200);
   c_hs_ovc: cover property (hs_cnt_r == 16'd50);
   c_slverr: cover property (pready && pslverr);
endmodule
bind sbpf_top sbpf_properties u_props (.clock(clock), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .br_sense(br_sense),
   .hs_sense(hs_sense), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive),
   .global_fault_flag(global_fault_flag));
`default_nettype wire

// ---- bench/sbpf_load_model.sv ----
`default_nettype none
module sbpf_load_model (
   input  wire logic [7:0]               drive,
   input  wire logic [1:0]               br_ovc,
   input  wire logic [1:0]               br_batt,
   input  wire logic [1:0]               br_open,
   input  wire logic [3:0]               hs_ovc,
   output var sbpf_pkg::sbpf_br_sense_t [1:0] br_sense,
   output var sbpf_pkg::sbpf_hs_sense_t [3:0] hs_sense
);
   timeunit 1ns;
   timeprecision 1ns;
   import sbpf_pkg::*;
   logic [1:0] br_on;
   logic [3:0] hs_on;
   assign br_on = {|drive[7:4], |drive[3:0]};
   assign hs_on = {drive[5], drive[4], drive[2], drive[0]};
   // healthy bridge idles between thresholds; healthy high side is pulled low
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         br_sense[b] = '{br_ovc[b] && br_on[b], br_open[b] && br_on[b],
                         br_batt[b] && !br_on[b], 1'b1};
      end
      for (int h = 0; h < 4; h++) begin
         hs_sense[h] = '{hs_ovc[h] && hs_on[h], 1'b0, 1'b0};
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sbpf_pkg::*;
   logic                 clock = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h0;
   logic [1:0]           br_ovc = 2'h0;
   logic [1:0]           br_batt = 2'h0;
   logic [1:0]           br_open = 2'h0;
   logic [3:0]           hs_ovc = 4'h0;
   sbpf_br_sense_t [1:0] br_sense;
   sbpf_hs_sense_t [3:0] hs_sense;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [7:0]           drive;
   logic                 global_fault_flag;
   logic [31:0]          q;
   logic                 e;
   int                   checks = 0;
   int                   miscompares = 0;
   int                   cycles = 0;
   always #20 clock = ~clock;
   sbpf_top #(.BR_BLANK_CYC(16'h0014), .HS_BLANK_CYC(16'h0014)) dut (.clock(clock),
      .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .br_sense(br_sense), .hs_sense(hs_sense), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drive(drive), .global_fault_flag(global_fault_flag));
   sbpf_load_model u_load (.drive(drive), .br_ovc(br_ovc), .br_batt(br_batt), .hs_ovc(hs_ovc),
      .br_open(br_open), .br_sense(br_sense), .hs_sense(hs_sense));
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // pready is read at the rising edge, before that edge updates it
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pos(input logic [9:0] exp);
      logic [6:0] up;
      apb(1'b0, ADDR_POS_UP, 32'h0);
      up = q[6:0];
      apb(1'b0, ADDR_POS_LO, 32'h0);
      chk({20'h0, up[6:5], up[4:0], q[4:0]}, {20'h0, q[6:5], exp});
   endtask
   // direction goes out one frame ahead of the pulse
   task automatic step(input logic [31:0] d);
      apb(1'b1, ADDR_CTRL, d);
      apb(1'b1, ADDR_CTRL, d | 32'h4);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic finish_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      pos(10'h200);
      apb(1'b1, ADDR_CTRL, 32'h1);
      cyc(2);
      chk({24'h0, drive}, 32'h69);
      step(32'h3);
      cyc(2);
      chk({24'h0, drive}, 32'h99);
      apb(1'b1, ADDR_CTRL, 32'h7);
      pos(10'h201);
      $display("test step done");
      apb(1'b1, ADDR_CTRL, 32'h13);
      pos(10'h200);
      repeat (512) step(32'h3);
      pos(10'h3FF);
      repeat (1024) step(32'h1);
      pos(10'h000);
      step(32'h3);
      pos(10'h001);
      $display("test saturation done");
      br_ovc[0] <= 1'b1;
      cyc(300);
      chk({31'h0, |drive[3:0]}, 32'h0);
      chk({31'h0, global_fault_flag}, 32'h1);
      @(posedge clock);
      br_ovc[0] <= 1'b0;
      apb(1'b0, ADDR_BR1_DIAG, 32'h0);
      chk(q & 32'h7, 32'h4);
      apb(1'b0, ADDR_BR2_DIAG, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, ADDR_BR1_DIAG, 32'h0);
      chk(q & 32'h7, 32'h0);
      step(32'h3);
      cyc(2);
      chk({31'h0, |drive[3:0]}, 32'h1);
      $display("test bridge overcurrent done");
      // load model has no residual motion, so the settle wait is cut short
      apb(1'b1, ADDR_CTRL, 32'h0);
      br_batt[0] <= 1'b1;
      cyc(3000);
      chk({31'h0, global_fault_flag}, 32'h0);
      cyc(300);
      chk({31'h0, global_fault_flag}, 32'h1);
      @(posedge clock);
      br_batt[0] <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h1);
      cyc(2);
      chk({31'h0, |drive}, 32'h1);
      apb(1'b0, ADDR_BR1_DIAG, 32'h0);
      chk(q & 32'h7, 32'h2);
      $display("test off diagnosis done");
      apb(1'b1, ADDR_CTRL, 32'h108);
      cyc(2);
      chk({31'h0, drive[0]}, 32'h1);
      @(posedge clock);
      hs_ovc[0] <= 1'b1;
      cyc(120);
      chk({31'h0, drive[0]}, 32'h0);
      apb(1'b0, ADDR_HS_DIAG, 32'h0);
      hs_ovc[0] <= 1'b0;
      chk(q & 32'h3, 32'h1);
      cyc(2);
      chk({31'h0, drive[0]}, 32'h1);
      apb(1'b0, ADDR_HS_DIAG, 32'h0);
      chk(q, 32'h0);
      $display("test high side done");
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      br_open[0] <= 1'b1;
      cyc(520);
      chk({31'h0, global_fault_flag}, 32'h1);
      @(posedge clock);
      br_open[0] <= 1'b0;
      cyc(10);
      chk({31'h0, global_fault_flag}, 32'h0);
      @(posedge clock);
      br_open[0] <= 1'b1;
      cyc(520);
      step(32'h3);
      apb(1'b0, ADDR_BR1_DIAG, 32'h0);
      chk(q & 32'h7, 32'h6);
      cyc(520);
      apb(1'b0, ADDR_BR1_DIAG, 32'h0);
      chk(q & 32'h7, 32'h5);
      $display("test open load done");
      apb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test unmapped done");
      finish_test();
   end
endmodule
`default_nettype wire
